/* pkg/gcsp_pkg.sv */
// Package of offsets, fields and reset values for the global pin block
package gcsp_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_INTPIN   = 8'h04;
    localparam logic [7:0] ADDR_GPIO     = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0c;
    localparam logic [7:0] ADDR_EVT      = 8'h10;
    localparam logic [7:0] ADDR_EVTCLR   = 8'h14;
    localparam logic [7:0] ADDR_EVTEN    = 8'h18;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_EXTSWMODE = 0;
    localparam int CTRL_RATEFAM   = 1;
    localparam int CTRL_DIG1FAM   = 2;
    localparam int CTRL_DIG2FAM   = 3;
    localparam int CTRL_REFFAILEN = 4;
    localparam int CTRL_LOCKEN    = 5;
    // ------------------------------------------------------------
    // Interrupt pin config fields
    // ------------------------------------------------------------
    localparam int INTP_ABSENTMODE = 0;
    localparam int INTP_ACTHIGH    = 1;
    localparam int INTP_OPENDRAIN  = 2;
    localparam int INTP_GPOMODE    = 3;
    localparam int INTP_GPOVAL     = 4;
    // ------------------------------------------------------------
    // GPIO fields
    // ------------------------------------------------------------
    localparam int IO4_DIR = 0;
    localparam int IO4_OUT = 1;
    // ------------------------------------------------------------
    // Status and event fields
    // ------------------------------------------------------------
    localparam int ST_IO4PIN  = 0;
    localparam int ST_LOCKED  = 1;
    localparam int ST_REFFAIL = 2;
    localparam int ST_REFLOST = 3;
    localparam int EVT_REFFAIL = 0;
    localparam int EVT_LOCKCHG = 1;
    localparam int EVT_REFLOST = 2;
    localparam int EVT_W       = 3;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0] CTRL_RST   = 6'h00;
    localparam logic [4:0] INTP_RST   = 5'h00;
    localparam logic [1:0] GPIO_RST   = 2'h0;
    localparam logic [2:0] EVT_RST    = 3'h0;
    localparam int         RST_MIN_CYCLES = 2;
    // Rate family encodings
    localparam logic RATE_SDH   = 1'b0;
    localparam logic RATE_SONET = 1'b1;
    // Strap capture sequencer
    typedef enum logic [1:0] {GCSP_IN_RESET, GCSP_SETTLE, GCSP_CAPTURE, GCSP_RUN} gcsp_state_t;
endpackage : gcsp_pkg

/* tb/gcsp_board_model.sv */
// Board side of the strap pin and the interrupt pin
module gcsp_board_model (
    input  wire logic pinOut,
    input  wire logic pinOe,
    input  wire logic boardLevel,
    output logic      pinLevel,
    input  wire logic intPinOut,
    input  wire logic intPinOe,
    output logic      intLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    // Strap is a weak resistor, so the block wins when it drives
    assign pinLevel = pinOe ? pinOut : boardLevel;
    // Pull-up on the board covers the open-drain case
    assign intLevel = intPinOe ? intPinOut : 1'b1;
endmodule : gcsp_board_model

/* tb/gcsp_global_pins_properties.sv */
// Checker of port timing for the global pin block
module gcsp_global_pins_properties (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       pllLocked,
    input wire logic       lockOut,
    input wire logic       refFailLatched,
    input wire logic       refFailOut,
    input wire logic       refFailOe,
    input wire logic       rateFamily,
    input wire logic       dig1RateFamily,
    input wire logic       dig2RateFamily,
    input wire logic       rateFamilyPinOe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Two sync flops plus the output register
    lock_follow_a: assert property (lockOut |-> $past(pllLocked, 3))
        else $error("lock pin high without lock");
    reffail_follow_a: assert property (refFailOe |-> refFailOut == $past(refFailLatched, 3))
        else $error("ref-fail pin not following status");
    strap_equal_a: assert property ($rose(nrst) |-> ##5 (rateFamily == dig1RateFamily
        && dig1RateFamily == dig2RateFamily))
        else $error("family bits differ after capture");
    io4_input_a: assert property ($rose(nrst) |-> !rateFamilyPinOe [*4])
        else $error("io4 driven right after reset");
    ready_after_a: assert property (psel && !penable |=> pready)
        else $error("no ready in access phase");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    error_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_error_a: assert property (psel && !penable && paddr > 8'h18 |=> pslverr)
        else $error("unmapped access without error");
endmodule : gcsp_global_pins_properties

/* tb/gcsp_global_pins_tb.sv */
// Testbench of the global pin block
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module gcsp_global_pins_tb;
    import gcsp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, boardLevel = 0;
    logic        srcSwitchPin = 0, refFailLatched = 0, pllLocked = 0, refActivityLost = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rs = 32'd87, r, prdata;
    logic        pready, pslverr, rateFamilyPinIn, rateFamilyPinOut, rateFamilyPinOe, irq;
    logic        selectAltPair, rateFamily, dig1RateFamily, dig2RateFamily, intLevel, fam;
    logic        refFailOut, refFailOe, lockOut, intPinOut, intPinOe;
    logic [32:0] rdQ[$];
    int          failures = 0, samples_checked = 0;
    logic [4:0]  cfg[7] = '{5'h01, 5'h02, 5'h00, 5'h04, 5'h18, 5'h08, 5'h06};
    logic [1:0]  pinExp[7] = '{2'b11, 2'b10, 2'b11, 2'b01, 2'b11, 2'b10, 2'b10};
    gcsp_global_pins i_gcsp_global_pins (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .srcSwitchPin, .rateFamilyPinIn, .rateFamilyPinOut,
        .rateFamilyPinOe, .refFailLatched, .pllLocked, .refActivityLost, .selectAltPair,
        .rateFamily, .dig1RateFamily, .dig2RateFamily, .refFailOut, .refFailOe, .lockOut,
        .intPinOut, .intPinOe, .irq);
    gcsp_board_model i_gcsp_board_model (.pinOut(rateFamilyPinOut), .pinOe(rateFamilyPinOe),
        .boardLevel, .pinLevel(rateFamilyPinIn), .intPinOut, .intPinOe, .intLevel);
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs
    task automatic end_sim();
        $display("checked %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // Release at the edge, so the next call starts one edge later
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!pready && n < 50);
        if (!pready) begin failures++; end_sim(); end
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rdQ.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wt
    task automatic reset();
        nrst <= 0;
        wt(3);
        `CHK({irq, lockOut, refFailOe, rateFamilyPinOe, intPinOe}, 5'h0)
        wt(17);
        nrst <= 1;
        wt(8);
    endtask : reset
    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite && rdQ.size() > 0) begin
            `CHK({pslverr, prdata}, rdQ.pop_front())
        end
    end
    initial begin
        wt(20000);
        failures++;
        end_sim();
    end
    initial begin
        wt(1);
        for (int v = 0; v < 2; v++) begin
            srcSwitchPin <= v[0];
            boardLevel <= ~v[0];
            reset();
            fam = v[0] ? RATE_SDH : RATE_SONET;
            `CHK({rateFamily, dig1RateFamily, dig2RateFamily}, {3{fam}})
            rd(ADDR_CTRL, {27'h0, 2'b00, {3{~v[0]}}, v[0]});
        end
        $display("test straps done");
        for (int i = 0; i < 6; i++) begin
            r = xs();
            srcSwitchPin <= r[0];
            wt(4);
            `CHK(selectAltPair, r[0])
        end
        srcSwitchPin <= 1;
        wr(ADDR_CTRL, 32'h0);
        wt(4);
        `CHK(selectAltPair, 1'b0)
        $display("test source switch done");
        wr(ADDR_GPIO, 32'h3);
        wt(4);
        `CHK({rateFamilyPinOe, rateFamilyPinIn}, 2'b11)
        rd(ADDR_STATUS, 33'h1);
        wr(ADDR_GPIO, 32'h2);
        wt(4);
        rd(ADDR_STATUS, 33'h0);
        $display("test io4 done");
        refFailLatched <= 1;
        pllLocked <= 1;
        wr(ADDR_CTRL, 32'h31);
        wt(4);
        `CHK({refFailOe, refFailOut, lockOut}, 3'b111)
        rd(ADDR_STATUS, 33'h6);
        wr(ADDR_CTRL, 32'h01);
        wt(2);
        `CHK({refFailOe, lockOut}, 2'b00)
        $display("test status pins done");
        wr(ADDR_EVTCLR, 32'h7);
        rd(ADDR_EVT, 33'h0);
        wr(ADDR_EVTEN, 32'h3);
        refActivityLost <= 1;
        wt(5);
        `CHK(irq, 1'b0)
        rd(ADDR_EVT, 33'h4);
        wr(ADDR_EVTEN, 32'h4);
        wt(2);
        `CHK({irq, intPinOe, intLevel}, 3'b110)
        wr(ADDR_EVTCLR, 32'h4);
        wt(3);
        `CHK({irq, intLevel}, 2'b01)
        $display("test interrupt done");
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_INTPIN, {27'h0, cfg[i]});
            wt(2);
            `CHK({intPinOe, intLevel}, pinExp[i])
        end
        wr(ADDR_INTPIN, 32'h1);
        refActivityLost <= 0;
        wt(4);
        `CHK(intLevel, 1'b0)
        rd(8'h40, {1'b1, 32'h0});
        rd(ADDR_EVTCLR, 33'h0);
        wr(ADDR_STATUS, 32'hf);
        rd(ADDR_STATUS, 33'h6);
        pllLocked <= 0;
        wr(ADDR_CTRL, 32'h20);
        wt(4);
        `CHK({lockOut, refFailOe}, 2'b00)
        $display("test pin modes done");
        wt(2);
        end_sim();
    end
endmodule : gcsp_global_pins_tb
bind gcsp_global_pins gcsp_global_pins_properties i_gcsp_global_pins_properties (.clk_sys,
    .nrst, .psel, .penable, .paddr, .pready, .pslverr, .pllLocked, .lockOut, .refFailLatched,
    .refFailOut, .refFailOe, .rateFamily, .dig1RateFamily, .dig2RateFamily, .rateFamilyPinOe);

/* verilog/gcsp_global_pins.sv */
// Global control and status pin logic with APB register access

// Contract
// - Low reset clears all state asynchronously
// - Reset release captures source-switch strap into mode
// - Switch pin picks clock pair 3/5 or 4/6
// - Rate-family strap sets three family bits
// - Family 0 is SDH, 1 is SONET
// - Rate-family pin becomes general IO 4
// - Ref-fail pin follows status or floats
// - Lock pin shows lock or drives low
// - Mode bit picks interrupt or loss function
// - Interrupt mode: polarity, drive, or GPO
// - Loss mode shows live activity monitor
module gcsp_global_pins (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        srcSwitchPin,
    input  wire logic        rateFamilyPinIn,
    output logic             rateFamilyPinOut,
    output logic             rateFamilyPinOe,
    input  wire logic        refFailLatched,
    input  wire logic        pllLocked,
    input  wire logic        refActivityLost,
    output logic             selectAltPair,
    output logic             rateFamily,
    output logic             dig1RateFamily,
    output logic             dig2RateFamily,
    output logic             refFailOut,
    output logic             refFailOe,
    output logic             lockOut,
    output logic             intPinOut,
    output logic             intPinOe,
    output logic             irq
);
    import gcsp_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Two stages each: fast_source_switch_pin, ioPin, refFail, locked, refLost
    logic [4:0] meta_q, meta_d, sync_q, sync_d;
    logic srcSwS, ioPinS, refFailS, lockedS, refLostS;

    always_comb begin
        meta_d = {refActivityLost, pllLocked, refFailLatched, rateFamilyPinIn, srcSwitchPin};
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 5'h00;
            sync_q <= 5'h00;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign srcSwS   = sync_q[0];
    assign ioPinS   = sync_q[1];
    assign refFailS = sync_q[2];
    assign lockedS  = sync_q[3];
    assign refLostS = sync_q[4];

    // ------------------------------------------------------------
    // Strap capture after reset release
    // ------------------------------------------------------------
    // Waits until synchronisers hold post-reset pin levels
    gcsp_state_t state_q, state_d;

    always_comb begin
        case (state_q)
            GCSP_IN_RESET: state_d = GCSP_SETTLE;
            GCSP_SETTLE:   state_d = GCSP_CAPTURE;
            GCSP_CAPTURE:  state_d = GCSP_RUN;
            GCSP_RUN:      state_d = GCSP_RUN;
            default:       state_d = GCSP_IN_RESET;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= GCSP_IN_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [5:0]       ctrl_q, ctrl_d;
    logic [4:0]       intp_q, intp_d;
    logic [1:0]       gpio_q, gpio_d;
    logic [EVT_W-1:0] evt_q, evt_d, evtEn_q, evtEn_d;
    logic             lockedPrev_q, lockedPrev_d, refFailPrev_q, refFailPrev_d;
    logic             refLostPrev_q, refLostPrev_d;
    logic [31:0]      prdata_q, prdata_d;
    logic             pready_q, pready_d, pslverr_q, pslverr_d;
    logic             wrEn, rdEn, hit;
    logic [EVT_W-1:0] evtSet;

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == ADDR_CTRL) || (a == ADDR_INTPIN) || (a == ADDR_GPIO) ||
                     (a == ADDR_STATUS) || (a == ADDR_EVT) || (a == ADDR_EVTCLR) ||
                     (a == ADDR_EVTEN);
    endfunction : known_addr

    always_comb begin
        wrEn = psel && !penable && pwrite;
        rdEn = psel && !penable && !pwrite;
        hit  = known_addr(paddr);
        ctrl_d = ctrl_q;
        intp_d = intp_q;
        gpio_d = gpio_q;
        evtEn_d = evtEn_q;
        lockedPrev_d  = lockedS;
        refFailPrev_d = refFailS;
        refLostPrev_d = refLostS;
        evtSet = '0;
        if (state_q != GCSP_IN_RESET && state_q != GCSP_SETTLE) begin
            evtSet[EVT_REFFAIL] = refFailS && !refFailPrev_q;
            evtSet[EVT_LOCKCHG] = lockedS != lockedPrev_q;
            evtSet[EVT_REFLOST] = refLostS && !refLostPrev_q;
        end
        evt_d = evt_q;
        if (wrEn && paddr == ADDR_EVTCLR) begin
            evt_d = evt_q & ~pwdata[EVT_W-1:0];
        end
        evt_d = evt_d | evtSet; // set wins over clear
        if (state_q == GCSP_CAPTURE) begin
            ctrl_d[CTRL_EXTSWMODE] = srcSwS;
            ctrl_d[CTRL_RATEFAM]   = ioPinS;
            ctrl_d[CTRL_DIG1FAM]   = ioPinS;
            ctrl_d[CTRL_DIG2FAM]   = ioPinS;
        end
        if (wrEn) begin
            case (paddr)
                ADDR_CTRL:   ctrl_d  = pwdata[5:0];
                ADDR_INTPIN: intp_d  = pwdata[4:0];
                ADDR_GPIO:   gpio_d  = pwdata[1:0];
                ADDR_EVTEN:  evtEn_d = pwdata[EVT_W-1:0];
                default: begin
                end
            endcase
        end
        // Answer in setup cycle's next edge: one wait-free access
        pready_d  = psel && !penable;
        pslverr_d = psel && !penable && !hit;
        prdata_d  = prdata_q;
        if (rdEn) begin
            case (paddr)
                ADDR_CTRL:   prdata_d = {26'h0, ctrl_q};
                ADDR_INTPIN: prdata_d = {27'h0, intp_q};
                ADDR_GPIO:   prdata_d = {30'h0, gpio_q};
                ADDR_STATUS: prdata_d = {28'h0, refLostS, refFailS, lockedS, ioPinS};
                ADDR_EVT:    prdata_d = {29'h0, evt_q};
                ADDR_EVTEN:  prdata_d = {29'h0, evtEn_q};
                default:     prdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_q        <= CTRL_RST;
            intp_q        <= INTP_RST;
            gpio_q        <= GPIO_RST;
            evt_q         <= EVT_RST;
            evtEn_q       <= EVT_RST;
            lockedPrev_q  <= 1'b0;
            refFailPrev_q <= 1'b0;
            refLostPrev_q <= 1'b0;
            prdata_q      <= 32'h0;
            pready_q      <= 1'b0;
            pslverr_q     <= 1'b0;
        end else begin
            ctrl_q        <= ctrl_d;
            intp_q        <= intp_d;
            gpio_q        <= gpio_d;
            evt_q         <= evt_d;
            evtEn_q       <= evtEn_d;
            lockedPrev_q  <= lockedPrev_d;
            refFailPrev_q <= refFailPrev_d;
            refLostPrev_q <= refLostPrev_d;
            prdata_q      <= prdata_d;
            pready_q      <= pready_d;
            pslverr_q     <= pslverr_d;
        end
    end

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    logic [11:0] pins_q, pins_d;
    logic        intLevel;
    logic        running;

    always_comb begin
        running = (state_q == GCSP_RUN);
        // Interrupt-mode source level, polarity applied after
        intLevel = intp_q[INTP_GPOMODE] ? intp_q[INTP_GPOVAL] : |(evt_q & evtEn_q);
        if (!intp_q[INTP_GPOMODE]) begin
            intLevel = intp_q[INTP_ACTHIGH] ? intLevel : !intLevel;
        end
        pins_d[0] = running && ctrl_q[CTRL_EXTSWMODE] && srcSwS;
        pins_d[1] = ctrl_q[CTRL_RATEFAM];
        pins_d[2] = ctrl_q[CTRL_DIG1FAM];
        pins_d[3] = ctrl_q[CTRL_DIG2FAM];
        pins_d[4] = gpio_q[IO4_OUT];
        // Pin is still a strap input until capture is done
        pins_d[5] = running && gpio_q[IO4_DIR];
        pins_d[6] = refFailS;
        pins_d[7] = ctrl_q[CTRL_REFFAILEN];
        pins_d[8] = ctrl_q[CTRL_LOCKEN] && lockedS;
        if (intp_q[INTP_ABSENTMODE]) begin
            pins_d[9]  = refLostS;
            pins_d[10] = 1'b1;
        end else if (intp_q[INTP_OPENDRAIN] && !intp_q[INTP_GPOMODE]) begin
            // Open drain: drive low only, output level held at 0
            pins_d[9]  = 1'b0;
            pins_d[10] = !intLevel;
        end else begin
            pins_d[9]  = intLevel;
            pins_d[10] = 1'b1;
        end
        pins_d[11] = |(evt_q & evtEn_q);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pins_q <= 12'h000;
        end else begin
            pins_q <= pins_d;
        end
    end

    assign selectAltPair    = pins_q[0];
    assign rateFamily       = pins_q[1];
    assign dig1RateFamily   = pins_q[2];
    assign dig2RateFamily   = pins_q[3];
    assign rateFamilyPinOut = pins_q[4];
    assign rateFamilyPinOe  = pins_q[5];
    assign refFailOut       = pins_q[6];
    assign refFailOe        = pins_q[7];
    assign lockOut          = pins_q[8];
    assign intPinOut        = pins_q[9];
    assign intPinOe         = pins_q[10];
    assign irq              = pins_q[11];
    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
endmodule : gcsp_global_pins
